// >>> port_pkg.sv
package port_pkg;

    // Byte addresses on the processor's internal bus.
    localparam logic [19:0] ADDR_PORT0       = 20'hFFF00;
    localparam logic [19:0] ADDR_PORT4       = 20'hFFF04;
    localparam logic [19:0] ADDR_DIR0        = 20'hFFF20;
    localparam logic [19:0] ADDR_DIR4        = 20'hFFF24;
    localparam logic [19:0] ADDR_OPEN_DRAIN0 = 20'hF0050;
    localparam logic [19:0] ADDR_ANALOG0     = 20'hF0060;
    localparam logic [19:0] ADDR_REDIRECT    = 20'hF0077;

    // Values after reset and masks of implemented bits.
    localparam logic [7:0] REDIRECT_RESET    = 8'h00;
    localparam logic [7:0] REDIRECT_MASK     = 8'h07;
    localparam logic [7:0] LATCH_RESET       = 8'h00;
    localparam logic [7:0] DIR_RESET         = 8'hFF;
    localparam logic [7:0] ANALOG_RESET      = 8'hFF;
    localparam logic [7:0] ANALOG_FIXED      = 8'hE1;
    localparam logic [7:0] OPEN_DRAIN_RESET  = 8'h00;
    localparam logic [7:0] OPEN_DRAIN_MASK   = 8'h01;
    localparam logic [7:0] PORT0_PIN_MASK    = 8'h1F;
    localparam logic [7:0] PORT4_PIN_MASK    = 8'h01;

    // Field positions inside the redirect register.
    localparam int BUZZER_REDIRECT_POS  = 0;
    localparam int TIMER1_REDIRECT_POS  = 1;
    localparam int EXTINT1_REDIRECT_POS = 2;

    // Synchroniser depth for pin inputs.
    localparam int SYNC_STAGES = 3;

    // Kinds of processor access; set and clear are read-modify-write.
    typedef enum logic [1:0] {
        ACCESS_READ  = 2'b00,
        ACCESS_WRITE = 2'b01,
        ACCESS_SET   = 2'b10,
        ACCESS_CLEAR = 2'b11
    } access_kind_type;

    typedef struct packed {
        logic            valid;
        access_kind_type kind;
        logic [19:0]     addr;
        logic [7:0]      data;
    } bus_request_type;

    typedef struct packed {
        logic       valid;
        logic       mapped;
        logic [7:0] data;
    } bus_response_type;

    // Outputs of the serial, timer and clock units toward the pins.
    typedef struct packed {
        logic serial_data_out;
        logic serial_clock_out;
        logic timer0_output;
        logic timer_channel1_output;
        logic clock_buzzer_output;
    } alt_output_type;

    // Serial lines idle high, timer and buzzer outputs idle low.
    localparam alt_output_type ALT_RESET = 5'h18;

    // Value a port read returns: pin level for input bits, latch otherwise.
    function automatic logic [7:0] port_read_value(input logic [7:0] latch,
                                                   input logic [7:0] pins,
                                                   input logic [7:0] dir);
        port_read_value = (dir & pins) | (~dir & latch);
    endfunction

endpackage

// >>> pin_sync3.sv
module pin_sync3 #(
    parameter int WIDTH = 9
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             srst,
    // Raw pins and filtered level.
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // A change counts only once the last two stages agree, so one bad sample is dropped.
    always_comb begin
        next_level = level;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_level[i] = stage3[i];
            end
        end
    end

    // Stage one is read only by stage two.
    always_ff @(posedge clk) begin
        if (srst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule

// >>> pin_output_cell.sv
module pin_output_cell (
    // Sources combined onto the pin.
    input  wire logic latch,
    input  wire logic serial_out,
    input  wire logic other_out,
    // Pin configuration.
    input  wire logic open_drain,
    input  wire logic drive_enable,
    // Pin drive.
    output logic      pin_out,
    output logic      pin_oe
);

    logic level;

    // Latch and serial output meet in an AND, the other units join through an OR.
    assign level = (latch & serial_out) | other_out;

    // Open drain only pulls low; a high level releases the pin.
    always_comb begin
        if (open_drain) begin
            pin_out = 1'b0;
            pin_oe  = drive_enable & ~level;
        end else begin
            pin_out = level;
            pin_oe  = drive_enable;
        end
    end

endmodule

// >>> port_latch_and_pin_redirect.sv
module port_latch_and_pin_redirect (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        srst,
    // Processor access.
    input  wire port_pkg::bus_request_type   bus_req,
    output port_pkg::bus_response_type       bus_rsp,
    // Port pins.
    input  wire logic [7:0]                  port0_pin_in,
    output logic      [7:0]                  port0_pin_out,
    output logic      [7:0]                  port0_pin_oe,
    input  wire logic                        port4_bit0_pin_in,
    output logic                             port4_bit0_pin_out,
    output logic                             port4_bit0_pin_oe,
    // Peripheral units.
    input  wire port_pkg::alt_output_type    alt_out,
    output logic                             external_interrupt_1,
    output logic                             timer_channel1_input
);

    logic [7:0]                 port_output_latch0;
    logic [7:0]                 port_output_latch4;
    logic [7:0]                 port_direction0;
    logic [7:0]                 port_direction4;
    logic [7:0]                 analog_select_register;
    logic [7:0]                 open_drain_select_register;
    logic [7:0]                 peripheral_pin_redirect;
    port_pkg::bus_response_type next_rsp;
    logic [7:0]                 next_latch0;
    logic [7:0]                 next_latch4;
    logic [7:0]                 next_dir0;
    logic [7:0]                 next_dir4;
    logic [7:0]                 next_analog;
    logic [7:0]                 next_open_drain;
    logic [7:0]                 next_redirect;
    logic [8:0]                 pin_level;
    logic [7:0]                 pins0;
    logic [7:0]                 pins4;
    logic [7:0]                 read0;
    logic [7:0]                 read4;
    port_pkg::alt_output_type   alt_q;
    logic [8:0]                 serial_in;
    logic [8:0]                 other_in;
    logic [8:0]                 latch_in;
    logic [8:0]                 open_drain_in;
    logic [8:0]                 drive_in;
    logic [8:0]                 cell_out;
    logic [8:0]                 cell_oe;
    logic                       buzzer_redirect_bit;
    logic                       timer1_redirect_bit;
    logic                       extint1_redirect_bit;
    logic                       next_extint;
    logic                       next_timer_in;
    logic                       is_rmw;

    // Pins come from the board and pass the three-stage filter.
    pin_sync3 #(
        .WIDTH (9)
    ) u_sync (
        .clk   (clk),
        .srst  (srst),
        .raw   ({port4_bit0_pin_in, port0_pin_in}),
        .level (pin_level)
    );

    assign pins0 = pin_level[7:0] & port_pkg::PORT0_PIN_MASK;
    assign pins4 = {7'h00, pin_level[8]};
    assign buzzer_redirect_bit  = peripheral_pin_redirect[port_pkg::BUZZER_REDIRECT_POS];
    assign timer1_redirect_bit  = peripheral_pin_redirect[port_pkg::TIMER1_REDIRECT_POS];
    assign extint1_redirect_bit = peripheral_pin_redirect[port_pkg::EXTINT1_REDIRECT_POS];

    assign read0  = port_pkg::port_read_value(port_output_latch0, pins0, port_direction0);
    assign read4  = port_pkg::port_read_value(port_output_latch4, pins4, port_direction4);
    assign is_rmw = (bus_req.kind == port_pkg::ACCESS_SET) || (bus_req.kind == port_pkg::ACCESS_CLEAR);

    // Register file: writes, read-modify-write and read answers.
    always_comb begin
        next_latch0     = port_output_latch0;
        next_latch4     = port_output_latch4;
        next_dir0       = port_direction0;
        next_dir4       = port_direction4;
        next_analog     = analog_select_register;
        next_open_drain = open_drain_select_register;
        next_redirect   = peripheral_pin_redirect;
        next_rsp        = '0;
        if (bus_req.valid) begin
            next_rsp.valid  = 1'b1;
            next_rsp.mapped = 1'b1;
            case (bus_req.addr)
                port_pkg::ADDR_PORT0: begin
                    next_rsp.data = read0;
                    if (bus_req.kind == port_pkg::ACCESS_WRITE) begin
                        next_latch0 = bus_req.data;
                    end
                    if (is_rmw) begin
                        next_latch0 = (bus_req.kind == port_pkg::ACCESS_SET) ? (read0 | bus_req.data)
                                                                            : (read0 & ~bus_req.data);
                    end
                end
                port_pkg::ADDR_PORT4: begin
                    next_rsp.data = read4;
                    if (bus_req.kind == port_pkg::ACCESS_WRITE) begin
                        next_latch4 = bus_req.data;
                    end
                    if (is_rmw) begin
                        next_latch4 = (bus_req.kind == port_pkg::ACCESS_SET) ? (read4 | bus_req.data)
                                                                            : (read4 & ~bus_req.data);
                    end
                end
                port_pkg::ADDR_DIR0: begin
                    next_rsp.data = port_direction0;
                    if (bus_req.kind == port_pkg::ACCESS_WRITE) begin
                        next_dir0 = bus_req.data;
                    end
                end
                port_pkg::ADDR_DIR4: begin
                    next_rsp.data = port_direction4;
                    if (bus_req.kind == port_pkg::ACCESS_WRITE) begin
                        next_dir4 = bus_req.data;
                    end
                end
                port_pkg::ADDR_ANALOG0: begin
                    next_rsp.data = analog_select_register;
                    if (bus_req.kind == port_pkg::ACCESS_WRITE) begin
                        next_analog = bus_req.data | port_pkg::ANALOG_FIXED;
                    end
                end
                port_pkg::ADDR_OPEN_DRAIN0: begin
                    next_rsp.data = open_drain_select_register;
                    if (bus_req.kind == port_pkg::ACCESS_WRITE) begin
                        next_open_drain = bus_req.data & port_pkg::OPEN_DRAIN_MASK;
                    end
                end
                port_pkg::ADDR_REDIRECT: begin
                    next_rsp.data = peripheral_pin_redirect;
                    if (bus_req.kind == port_pkg::ACCESS_WRITE) begin
                        next_redirect = bus_req.data & port_pkg::REDIRECT_MASK;
                    end
                end
                default: begin
                    next_rsp.mapped = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            port_output_latch0         <= port_pkg::LATCH_RESET;
            port_output_latch4         <= port_pkg::LATCH_RESET;
            port_direction0            <= port_pkg::DIR_RESET;
            port_direction4            <= port_pkg::DIR_RESET;
            analog_select_register     <= port_pkg::ANALOG_RESET;
            open_drain_select_register <= port_pkg::OPEN_DRAIN_RESET;
            peripheral_pin_redirect    <= port_pkg::REDIRECT_RESET;
            bus_rsp                    <= '0;
            alt_q                      <= port_pkg::ALT_RESET;
        end else begin
            port_output_latch0         <= next_latch0;
            port_output_latch4         <= next_latch4;
            port_direction0            <= next_dir0;
            port_direction4            <= next_dir4;
            analog_select_register     <= next_analog;
            open_drain_select_register <= next_open_drain;
            peripheral_pin_redirect    <= next_redirect;
            bus_rsp                    <= next_rsp;
            alt_q                      <= alt_out;
        end
    end

    // Per-pin sources; index 8 is the port 4 pin.
    always_comb begin
        serial_in = 9'h1FF;
        other_in  = 9'h000;
        open_drain_in = 9'h000;
        open_drain_in[0] = open_drain_select_register[0];
        serial_in[0] = alt_q.serial_data_out;
        serial_in[2] = alt_q.serial_clock_out;
        other_in[2] = ~buzzer_redirect_bit & alt_q.clock_buzzer_output;
        other_in[3] = alt_q.timer0_output;
        other_in[4] = ~timer1_redirect_bit & alt_q.timer_channel1_output;
        other_in[8] = (buzzer_redirect_bit & alt_q.clock_buzzer_output)
                    | (timer1_redirect_bit & alt_q.timer_channel1_output);
        latch_in = {port_output_latch4[0], port_output_latch0};
        // drive only digital outputs
        // Fixed ones in the analog register mark pins without analog input, so they never block the drive.
        drive_in = {~port_direction4[0],
                    ~port_direction0 & ~(analog_select_register & ~port_pkg::ANALOG_FIXED)
                    & port_pkg::PORT0_PIN_MASK};
    end

    for (genvar i = 0; i < 9; i++) begin : g_cell
        pin_output_cell u_cell (
            .latch        (latch_in[i]),
            .serial_out   (serial_in[i]),
            .other_out    (other_in[i]),
            .open_drain   (open_drain_in[i]),
            .drive_enable (drive_in[i]),
            .pin_out      (cell_out[i]),
            .pin_oe       (cell_oe[i])
        );
    end

    assign next_extint   = extint1_redirect_bit ? pin_level[3] : pin_level[0];
    assign next_timer_in = timer1_redirect_bit ? pin_level[8] : pin_level[4];

    // Pin drive and routed inputs leave through flip-flops, one cycle behind the sources.
    always_ff @(posedge clk) begin
        if (srst) begin
            port0_pin_out        <= 8'h00;
            port0_pin_oe         <= 8'h00;
            port4_bit0_pin_out   <= 1'b0;
            port4_bit0_pin_oe    <= 1'b0;
            external_interrupt_1 <= 1'b0;
            timer_channel1_input <= 1'b0;
        end else begin
            port0_pin_out        <= cell_out[7:0];
            port0_pin_oe         <= cell_oe[7:0];
            port4_bit0_pin_out   <= cell_out[8];
            port4_bit0_pin_oe    <= cell_oe[8];
            external_interrupt_1 <= next_extint;
            timer_channel1_input <= next_timer_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_redirect_reset: assert property ($fell(srst) |-> peripheral_pin_redirect == 8'h00)
        else $error("redirect register not zero after reset");
    a_latch_reset: assert property ($fell(srst) |-> port_output_latch0 == 8'h00 && port_output_latch4 == 8'h00)
        else $error("port latch not zero after reset");
    a_idle_levels: assert property ($fell(srst) |-> alt_q == 5'h18 && port0_pin_oe == 8'h00)
        else $error("inactive levels wrong after reset");
    a_redirect_write: assert property (bus_req.valid && bus_req.kind == port_pkg::ACCESS_WRITE
        && bus_req.addr == port_pkg::ADDR_REDIRECT |=> peripheral_pin_redirect == ($past(bus_req.data) & 8'h07))
        else $error("redirect write stored wrong value");
    a_extint_route: assert property (##1 external_interrupt_1 ==
        ($past(extint1_redirect_bit) ? $past(pin_level[3]) : $past(pin_level[0])))
        else $error("interrupt 1 taken from wrong pin");
    a_latch_write: assert property (bus_req.valid && bus_req.kind == port_pkg::ACCESS_WRITE
        && bus_req.addr == port_pkg::ADDR_PORT0 |=> port_output_latch0 == $past(bus_req.data))
        else $error("port write not latched");
    a_latch_hold: assert property (!(bus_req.valid && bus_req.kind != port_pkg::ACCESS_READ
        && bus_req.addr == port_pkg::ADDR_PORT0) |=> $stable(port_output_latch0))
        else $error("latch changed without a write");
    a_read_source: assert property (bus_req.valid && bus_req.kind == port_pkg::ACCESS_READ
        && bus_req.addr == port_pkg::ADDR_PORT0 |=> bus_rsp.valid
        && bus_rsp.data == (($past(port_direction0) & $past(pins0)) | (~$past(port_direction0) & $past(port_output_latch0))))
        else $error("port read returned wrong source");
    a_rmw_set: assert property (bus_req.valid && bus_req.kind == port_pkg::ACCESS_SET
        && bus_req.addr == port_pkg::ADDR_PORT0 |=> port_output_latch0 == ((($past(port_direction0) & $past(pins0))
        | (~$past(port_direction0) & $past(port_output_latch0))) | $past(bus_req.data)))
        else $error("set used wrong operand");
    a_input_undriven: assert property (port_direction0[1] |=> !port0_pin_oe[1])
        else $error("input-mode pin driven");
    a_plain_drive: assert property (!port_direction0[1] && !analog_select_register[1]
        |=> port0_pin_oe[1] && port0_pin_out[1] == $past(port_output_latch0[1]))
        else $error("output pin not driven from latch");
    a_bit0_drive: assert property (!port_direction0[0] && !open_drain_select_register[0]
        |=> port0_pin_oe[0])
        else $error("port 0 bit 0 not driven in output mode");

    c_redirect_write: cover property (bus_req.valid && bus_req.addr == port_pkg::ADDR_REDIRECT
        && bus_req.kind == port_pkg::ACCESS_WRITE);
    c_rmw_input: cover property (bus_req.valid && is_rmw && bus_req.addr == port_pkg::ADDR_PORT0
        && port_direction0 != 8'h00);
    c_buzzer_p40: cover property (buzzer_redirect_bit && alt_q.clock_buzzer_output && port4_bit0_pin_oe);

endmodule

// >>> pin_board.sv
module pin_board (
    // Design drive for the eight port 0 pins and the port 4 pin.
    input  wire logic [8:0] drive_out,
    input  wire logic [8:0] drive_oe,
    // Board pull levels and resolved pin levels.
    input  wire logic [8:0] pull_level,
    output logic      [8:0] pin_level
);
    timeunit 1ns;
    timeprecision 100ps;

    // A released pin falls back to its board pull level, never to the last driven value.
    assign pin_level = (drive_oe & drive_out) | (~drive_oe & pull_level);
endmodule

// >>> test_port_latch_and_pin_redirect.sv
module test_port_latch_and_pin_redirect;
    timeunit 1ns;
    timeprecision 100ps;

    logic                        clk = 1'b0;
    logic                        srst = 1'b1;
    port_pkg::bus_request_type   req = '0;
    port_pkg::bus_response_type  rsp;
    port_pkg::alt_output_type    alt = port_pkg::ALT_RESET;
    logic [7:0]                  p0_out;
    logic [7:0]                  p0_oe;
    logic                        p4_out;
    logic                        p4_oe;
    logic                        ext_int;
    logic                        tmr_in;
    logic [8:0]                  pull = 9'h000;
    logic [8:0]                  pins;
    logic [7:0]                  rd;
    int                          err_count = 0;
    int                          comparisons = 0;

    // Free-running clock of 8 ns.
    always #4 clk = ~clk;

    pin_board i_board (.drive_out({p4_out, p0_out}), .drive_oe({p4_oe, p0_oe}), .pull_level(pull), .pin_level(pins));

    port_latch_and_pin_redirect i_dut (.clk(clk), .srst(srst), .bus_req(req), .bus_rsp(rsp),
        .port0_pin_in(pins[7:0]), .port0_pin_out(p0_out), .port0_pin_oe(p0_oe),
        .port4_bit0_pin_in(pins[8]), .port4_bit0_pin_out(p4_out), .port4_bit0_pin_oe(p4_oe),
        .alt_out(alt), .external_interrupt_1(ext_int), .timer_channel1_input(tmr_in));

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compares one byte and reports a difference at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus access; it is entered at a falling edge and holds the request over one rising edge.
    task automatic access(input port_pkg::access_kind_type kind, input logic [19:0] addr,
                          input logic [7:0] data, input logic exp_mapped);
        int n;
        n = 0;
        req = '{valid: 1'b1, kind: kind, addr: addr, data: data};
        @(negedge clk);
        req.valid = 1'b0;
        while (rsp.valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            err_count++;
            give_verdict();
        end else begin
            rd = rsp.data;
            check({7'h00, rsp.mapped}, {7'h00, exp_mapped});
            @(negedge clk);
        end
    endtask

    // Main sequence; every input changes at a falling edge.
    initial begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_REDIRECT, 8'h00, 1'b1);
        check(rd, 8'h00);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_DIR0, 8'h00, 1'b1);
        check(rd, port_pkg::DIR_RESET);
        access(port_pkg::ACCESS_READ, 20'hF0078, 8'h00, 1'b0);
        check(rd, 8'h00);
        // Routed inputs follow the default pins, then the alternate ones.
        pull = 9'h101;
        repeat (8) @(negedge clk);
        check({6'h00, ext_int, tmr_in}, 8'h02);
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_REDIRECT, 8'hFE, 1'b1);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_REDIRECT, 8'h00, 1'b1);
        check(rd, 8'h06);
        repeat (8) @(negedge clk);
        check({6'h00, ext_int, tmr_in}, 8'h01);
        // Input mode: the latch takes the write, the pin stays released.
        pull = 9'h10A;
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_PORT0, 8'h15, 1'b1);
        repeat (8) @(negedge clk);
        check(p0_oe, 8'h00);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_PORT0, 8'h00, 1'b1);
        check(rd, 8'h0A);
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_ANALOG0, 8'h00, 1'b1);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_ANALOG0, 8'h00, 1'b1);
        check(rd, port_pkg::ANALOG_FIXED);
        // Output mode shows the latch written earlier in input mode.
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_DIR0, 8'hE0, 1'b1);
        check(p0_oe, 8'h1F);
        check(p0_out & 8'h1F, 8'h15);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_PORT0, 8'h00, 1'b1);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_PORT0, 8'h00, 1'b1);
        check(rd, 8'h15);
        access(port_pkg::ACCESS_SET, port_pkg::ADDR_PORT0, 8'h02, 1'b1);
        check(p0_out & 8'h1F, 8'h17);
        // Bit 4 back to input: its operand is the pulled-low pin, not the latch.
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_DIR0, 8'hF0, 1'b1);
        repeat (8) @(negedge clk);
        access(port_pkg::ACCESS_CLEAR, port_pkg::ADDR_PORT0, 8'h01, 1'b1);
        check(p0_oe, 8'h0F);
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_DIR0, 8'h00, 1'b1);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_PORT0, 8'h00, 1'b1);
        check(rd, 8'h06);
        // Serial clock low masks the latch on port 0 bit 2; timer 0 ORs onto bit 3.
        alt = 5'h14;
        repeat (3) @(negedge clk);
        check(p0_out & 8'h1F, 8'h0A);
        // Buzzer moved to the port 4 pin; bits 0 and 1 are never set together.
        // one shared-pin user
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_REDIRECT, 8'h05, 1'b1);
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_DIR4, 8'h00, 1'b1);
        alt = 5'h15;
        repeat (3) @(negedge clk);
        check({6'h00, p4_oe, p4_out}, 8'h03);
        // A second reset in mid-run clears latches and the redirect register.
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_REDIRECT, 8'h00, 1'b1);
        check(rd, 8'h00);
        access(port_pkg::ACCESS_WRITE, port_pkg::ADDR_DIR0, 8'h00, 1'b1);
        access(port_pkg::ACCESS_READ, port_pkg::ADDR_PORT0, 8'h00, 1'b1);
        check(rd, 8'h00);
        give_verdict();
    end
endmodule
